// File: verilog/psi_map.svh
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH
// ==========================================
// clock and timing
`define PSI_CLK_HZ 20000000
`define PSI_TICK_MS 25
`define PSI_TICK_CYCLES (`PSI_TICK_MS * (`PSI_CLK_HZ / 1000))
// ==========================================
// link speed codes
`define PSI_SPEED_10 2'h0
`define PSI_SPEED_100 2'h1
`define PSI_SPEED_1000 2'h2
// ==========================================
// individual-style function select
`define PSI_SEL_RSVD 2'h0
`define PSI_SEL_BLINK 2'h2
// ==========================================
// enhanced-style function codes
`define PSI_FN_LINK_ANY 4'h0
`define PSI_FN_LINK_1000 4'h1
`define PSI_FN_LINK_100 4'h2
`define PSI_FN_LINK_10 4'h3
`define PSI_FN_LINK_100_1000 4'h4
`define PSI_FN_LINK_10_1000 4'h5
`define PSI_FN_LINK_10_100 4'h6
`define PSI_FN_DUPLEX_COLL 4'h8
`define PSI_FN_COLL 4'h9
`define PSI_FN_ACT 4'ha
`define PSI_FN_PD_FAULT 4'hc
`define PSI_FN_FORCE_OFF 4'he
`define PSI_FN_FORCE_ON 4'hf
// ==========================================
// blink timing in ticks and reset values
`define PSI_BLINK_HALF_MAX 5'h08
`define PSI_STRETCH_MIN 5'h02
`define PSI_LEGACY_RATE 2'h2
`define PSI_ALL_OFF 5'h1f
`endif

// File: verilog/psi_pkg.sv
// ==========================================
// shared types
package psi_pkg;
  typedef enum logic [1:0] {psi_individual, psi_tricolour, psi_enhanced} psi_style_t;
  typedef enum logic [1:0] {psi_idle, psi_show, psi_rest} psi_blink_state_t;
endpackage

// File: verilog/psi_blink.sv
`timescale 1ns/100ps
`include "psi_map.svh"
module psi_blink
  import psi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic event_in,
  input wire logic stretch,
  input wire logic [1:0] rate,
  output logic active
);
  psi_blink_state_t state;
  logic [4:0] cnt;
  logic pend;
  logic [4:0] half;
  logic [4:0] len;
  logic [4:0] load;

  assign half = `PSI_BLINK_HALF_MAX >> rate;
  assign len = `PSI_STRETCH_MIN << rate;
  assign load = stretch ? len : half;
  assign active = (state == psi_show);

  // ==========================================
  // pending event, set wins over consume
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend <= 1'b0;
    // an event in idle starts the show itself and is not kept for a second blink
    end else if (event_in && state != psi_idle && !(stretch && state == psi_show)) begin
      pend <= 1'b1;
    end else if (state != psi_show && (state == psi_idle || (tick && cnt == 5'h01))) begin
      pend <= 1'b0;
    end
  end

  // ==========================================
  // blink or stretch sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= psi_idle;
      cnt <= 5'h00;
    end else begin
      case (state)
        psi_idle: begin
          if (event_in || pend) begin
            state <= psi_show;
            cnt <= stretch ? len : half;
          end
        end
        psi_show: begin
          if (stretch && event_in) begin
            cnt <= len;
          end else if (tick && cnt == 5'h01) begin
            state <= psi_rest;
            cnt <= stretch ? (len >> 1) : half;
          end else if (tick) begin
            cnt <= cnt - 5'h01;
          end
        end
        psi_rest: begin
          if (tick && cnt == 5'h01) begin
            state <= (pend || event_in) ? psi_show : psi_idle;
            cnt <= stretch ? len : half;
          end else if (tick) begin
            cnt <= cnt - 5'h01;
          end
        end
        default: begin
          state <= psi_idle;
          cnt <= 5'h00;
        end
      endcase
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence start_seq;
    state == psi_idle && event_in;
  endsequence
  event_starts_a: assert property (start_seq |=> active ##0 cnt == $past(load))
    else $error("event did not start a blink");
  rest_after_a: assert property ($fell(active) |-> !active ##1 (!active || $past(tick)))
    else $error("no off phase after blink");
endmodule

// File: verilog/psi_top.sv
`timescale 1ns/100ps
`include "psi_map.svh"
module psi_top
  import psi_pkg::*;
#(
  parameter int TICK_CYCLES = `PSI_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic full_duplex,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic collision,
  input wire logic parallel_detect_fault,
  input wire logic isolate_control,
  input wire logic power_down_control,
  input wire logic style_control,
  input wire logic style_strap,
  input wire logic [1:0] individual_function_select,
  input wire logic [15:0] led_config,
  input wire logic [3:0] combine_disable,
  input wire logic [3:0] pulse_stretch_enable,
  input wire logic [7:0] blink_rate,
  input wire logic activity_tx_only,
  output logic indicator_out_1_n,
  output logic indicator_out_2_n,
  output logic indicator_out_3_n,
  output logic indicator_out_4_n,
  output logic indicator_out_5_n
);
  // ==========================================
  // decoding helpers
  function automatic logic speed_is(input logic up, input logic [1:0] spd, input logic [1:0] code);
    speed_is = up && (spd == code);
  endfunction

  function automatic logic [1:0] enh_primary(input logic [3:0] code, input logic l10,
                                             input logic l100, input logic l1000,
                                             input logic fdl, input logic pdf);
    // returns {primary level, secondary turns lamp on}
    case (code)
      `PSI_FN_LINK_ANY: enh_primary = {l10 | l100 | l1000, 1'b0};
      `PSI_FN_LINK_1000: enh_primary = {l1000, 1'b0};
      `PSI_FN_LINK_100: enh_primary = {l100, 1'b0};
      `PSI_FN_LINK_10: enh_primary = {l10, 1'b0};
      `PSI_FN_LINK_100_1000: enh_primary = {l100 | l1000, 1'b0};
      `PSI_FN_LINK_10_1000: enh_primary = {l10 | l1000, 1'b0};
      `PSI_FN_LINK_10_100: enh_primary = {l10 | l100, 1'b0};
      `PSI_FN_DUPLEX_COLL: enh_primary = {fdl, 1'b1};
      `PSI_FN_COLL: enh_primary = 2'h1;
      `PSI_FN_ACT: enh_primary = 2'h1;
      `PSI_FN_PD_FAULT: enh_primary = {pdf, 1'b0};
      `PSI_FN_FORCE_OFF: enh_primary = 2'h0;
      `PSI_FN_FORCE_ON: enh_primary = 2'h2;
      default: enh_primary = 2'h0;
    endcase
  endfunction

  function automatic logic enh_event(input logic [3:0] code, input logic act,
                                     input logic coll, input logic link);
    case (code)
      `PSI_FN_LINK_ANY, `PSI_FN_LINK_1000, `PSI_FN_LINK_100, `PSI_FN_LINK_10,
      `PSI_FN_LINK_100_1000, `PSI_FN_LINK_10_1000, `PSI_FN_LINK_10_100,
      `PSI_FN_ACT: enh_event = act;
      `PSI_FN_DUPLEX_COLL, `PSI_FN_COLL: enh_event = coll & link;
      default: enh_event = 1'b0;
    endcase
  endfunction

  // ==========================================
  // strap capture and style
  logic strap_latched;
  psi_style_t style;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_latched <= style_strap;
    end
  end

  always_comb begin
    if (!style_control) begin
      style = psi_enhanced;
    end else if (strap_latched) begin
      style = psi_individual;
    end else begin
      style = psi_tricolour;
    end
  end

  // ==========================================
  // blink time base
  logic [19:0] tick_cnt;
  logic tick;

  always_ff @(posedge sys_clk) begin
    if (reset || tick_cnt == 20'(TICK_CYCLES - 1)) begin
      tick_cnt <= 20'h0_0000;
    end else begin
      tick_cnt <= tick_cnt + 20'h0_0001;
    end
  end

  assign tick = (tick_cnt == 20'(TICK_CYCLES - 1));

  // ==========================================
  // link status decode
  logic l10;
  logic l100;
  logic l1000;
  logic fd_link;
  logic act_any;
  logic act_sel;
  logic act_blink;
  logic coll_blink;

  assign l10 = speed_is(link_up, link_speed, `PSI_SPEED_10);
  assign l100 = speed_is(link_up, link_speed, `PSI_SPEED_100);
  assign l1000 = speed_is(link_up, link_speed, `PSI_SPEED_1000);
  assign fd_link = link_up && full_duplex;
  assign act_any = rx_activity | tx_activity;
  assign act_sel = activity_tx_only ? tx_activity : act_any;

  psi_blink u_act (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick),
    .event_in(act_any),
    .stretch(1'b0),
    .rate(`PSI_LEGACY_RATE),
    .active(act_blink)
  );

  psi_blink u_coll (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick),
    .event_in(collision & link_up),
    .stretch(1'b0),
    .rate(`PSI_LEGACY_RATE),
    .active(coll_blink)
  );

  // ==========================================
  // enhanced outputs 1 to 4
  logic [3:0] enh_lit;

  for (genvar i = 0; i < 4; i++) begin : g_enh
    logic [3:0] code;
    logic [1:0] prim;
    logic sec;

    assign code = led_config[4*i +: 4];
    assign prim = enh_primary(code, l10, l100, l1000, fd_link, parallel_detect_fault);

    psi_blink u_blink (
      .sys_clk(sys_clk),
      .reset(reset),
      .tick(tick),
      .event_in(enh_event(code, act_sel, collision, link_up)),
      .stretch(pulse_stretch_enable[i]),
      .rate(blink_rate[2*i +: 2]),
      .active(sec)
    );

    always_comb begin
      // codes 12 and up have no secondary, so a stale blink must not reach them
      if (combine_disable[i] || code >= `PSI_FN_PD_FAULT) begin
        enh_lit[i] = prim[1];
      end else if (prim[0]) begin
        enh_lit[i] = prim[1] | sec;
      end else begin
        enh_lit[i] = prim[1] & ~sec;
      end
    end
  end

  // ==========================================
  // lamp selection
  logic [4:0] next_lit;
  logic [4:0] out_n;
  logic sel_rsvd;
  logic sel_blink;
  logic tri_on2;
  logic tri_on1;

  assign sel_rsvd = (individual_function_select == `PSI_SEL_RSVD);
  assign sel_blink = (individual_function_select == `PSI_SEL_BLINK);
  assign tri_on2 = l1000 | l10;
  assign tri_on1 = l100 | l10;

  always_comb begin
    next_lit = 5'h00;
    // outputs 3 to 5 are shared by individual and tri-colour styles
    if (!sel_rsvd) begin
      next_lit[4] = l100 & ~(sel_blink & act_blink);
      next_lit[3] = l1000 & ~(sel_blink & act_blink);
      next_lit[2] = fd_link | coll_blink;
    end
    case (style)
      psi_individual: begin
        next_lit[1] = link_up;
        next_lit[0] = act_blink;
      end
      psi_tricolour: begin
        next_lit[1] = tri_on2 & ~act_blink;
        next_lit[0] = tri_on1 & ~act_blink;
      end
      psi_enhanced: begin
        next_lit = {1'b0, enh_lit};
      end
      default: begin
        next_lit = 5'h00;
      end
    endcase
    if (sel_rsvd && style != psi_enhanced) begin
      next_lit[4:2] = 3'h0;
    end
    if (power_down_control || (isolate_control && style != psi_enhanced)) begin
      next_lit = 5'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_n <= `PSI_ALL_OFF;
    end else begin
      out_n <= ~next_lit;
    end
  end

  assign indicator_out_1_n = out_n[0];
  assign indicator_out_2_n = out_n[1];
  assign indicator_out_3_n = out_n[2];
  assign indicator_out_4_n = out_n[3];
  assign indicator_out_5_n = out_n[4];

  // ==========================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence indiv_live;
    style == psi_individual && !isolate_control && !power_down_control;
  endsequence
  power_down_off_a: assert property (power_down_control |=> out_n == 5'h1f)
    else $error("lamp lit during power-down");
  isolate_off_a: assert property (isolate_control && style != psi_enhanced |=> &out_n)
    else $error("lamp lit during isolate");
  enh_out5_off_a: assert property (style == psi_enhanced |=> indicator_out_5_n)
    else $error("output 5 lit in enhanced style");
  force_on_a: assert property (style == psi_enhanced && !power_down_control &&
                               led_config[3:0] == 4'hf |=> !indicator_out_1_n)
    else $error("force on not lit");
  force_off_a: assert property (led_config[7:4] == 4'he && !style_control
                                |=> indicator_out_2_n)
    else $error("force off lit");
  reserved_sel_a: assert property (style != psi_enhanced && sel_rsvd
                                   |=> &out_n[4:2])
    else $error("reserved select lit output");
  link_any_a: assert property (indiv_live |=> indicator_out_2_n == !$past(link_up))
    else $error("link lamp wrong");
  tri_1000_a: assert property (style == psi_tricolour && l1000 && !act_blink &&
                               !isolate_control && !power_down_control
                               |=> !indicator_out_2_n && indicator_out_1_n)
    else $error("tri-colour 1000 encoding wrong");
  strap_hold_a: assert property (!reset |=> $stable(strap_latched))
    else $error("strap changed outside reset");
  duplex_lamp_a: assert property (indiv_live and (!sel_rsvd && fd_link)
                                  |=> !indicator_out_3_n)
    else $error("duplex lamp off");
endmodule

// File: bench/psi_lamp_bank.sv
`timescale 1ns/100ps
// ==========================================
// five indicator lamps behind series resistors
module psi_lamp_bank (
  input wire logic pin_1_n,
  input wire logic pin_2_n,
  input wire logic pin_3_n,
  input wire logic pin_4_n,
  input wire logic pin_5_n,
  output logic [4:0] lit
);
  // a lamp glows only while its pin is pulled low
  assign lit = ~{pin_5_n, pin_4_n, pin_3_n, pin_2_n, pin_1_n};
endmodule

// File: bench/psi_top_test.sv
`timescale 1ns/100ps
module psi_top_test;
  import psi_pkg::*;
  logic sys_clk, reset, link_up, full_duplex, rx_activity, tx_activity, collision;
  logic parallel_detect_fault, isolate_control, power_down_control;
  logic style_control, style_strap, activity_tx_only;
  logic [1:0] link_speed, individual_function_select;
  logic [15:0] led_config;
  logic [3:0] combine_disable, pulse_stretch_enable;
  logic [7:0] blink_rate;
  logic o1_n, o2_n, o3_n, o4_n, o5_n;
  logic [4:0] lit;
  int n_fail, checks_done, c;
  // ==========================================
  // design and lamps
  psi_top #(.TICK_CYCLES(4)) psi_top_inst (
    .sys_clk(sys_clk), .reset(reset), .link_up(link_up), .link_speed(link_speed),
    .full_duplex(full_duplex), .rx_activity(rx_activity), .tx_activity(tx_activity),
    .collision(collision), .parallel_detect_fault(parallel_detect_fault),
    .isolate_control(isolate_control), .power_down_control(power_down_control),
    .style_control(style_control), .style_strap(style_strap),
    .individual_function_select(individual_function_select), .led_config(led_config),
    .combine_disable(combine_disable), .pulse_stretch_enable(pulse_stretch_enable),
    .blink_rate(blink_rate), .activity_tx_only(activity_tx_only),
    .indicator_out_1_n(o1_n), .indicator_out_2_n(o2_n), .indicator_out_3_n(o3_n),
    .indicator_out_4_n(o4_n), .indicator_out_5_n(o5_n));
  psi_lamp_bank psi_lamp_bank_inst (.pin_1_n(o1_n), .pin_2_n(o2_n), .pin_3_n(o3_n),
    .pin_4_n(o4_n), .pin_5_n(o5_n), .lit(lit));
  // ==========================================
  // tasks
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic check_lamps(input logic [4:0] exp);
    settle();
    checks_done++;
    if (lit !== exp) begin
      n_fail++;
      $display("[FAIL] %0t lamps %b expected %b", $time, lit, exp);
    end
  endtask
  task automatic wait_lamp(input int idx, input logic val, input int limit);
    int k;
    k = 0;
    checks_done++;
    while (lit[idx] !== val && k < limit) begin
      @(negedge sys_clk);
      k++;
    end
    if (lit[idx] !== val) begin
      n_fail++;
      $display("[FAIL] %0t lamp %0d never reached %b", $time, idx + 1, val);
    end
  endtask
  task automatic hold_lamps(input logic [4:0] exp, input int n);
    repeat (n) check_lamps(exp);
  endtask
  task automatic pulse_rx();
    rx_activity = 1'b1;
    @(negedge sys_clk);
    rx_activity = 1'b0;
  endtask
  task automatic do_reset(input logic strap);
    reset = 1'b1;
    style_strap = strap;
    repeat (10) @(negedge sys_clk);
    check_lamps(5'h00);
    reset = 1'b0;
    style_strap = ~strap;
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  // ==========================================
  // tests
  initial begin
    {reset, link_up, full_duplex, rx_activity, tx_activity, collision} = 6'h20;
    {parallel_detect_fault, isolate_control, power_down_control} = 3'h0;
    {style_control, style_strap, activity_tx_only} = 3'h6;
    link_speed = 2'h2;
    individual_function_select = 2'h3;
    led_config = 16'h0000;
    combine_disable = 4'h0;
    pulse_stretch_enable = 4'h0;
    blink_rate = 8'h00;
    @(negedge sys_clk);
    do_reset(1'b1);
    check_lamps(5'h00);
    {link_up, full_duplex} = 2'h3;
    check_lamps(5'h0e);
    link_speed = 2'h1;
    check_lamps(5'h16);
    full_duplex = 1'b0;
    check_lamps(5'h12);
    link_speed = 2'h0;
    full_duplex = 1'b1;
    check_lamps(5'h06);
    link_speed = 2'h2;
    individual_function_select = 2'h0;
    check_lamps(5'h02);
    individual_function_select = 2'h1;
    check_lamps(5'h0e);
    isolate_control = 1'b1;
    check_lamps(5'h00);
    isolate_control = 1'b0;
    power_down_control = 1'b1;
    check_lamps(5'h00);
    power_down_control = 1'b0;
    individual_function_select = 2'h3;
    pulse_rx();
    wait_lamp(0, 1'b1, 20);
    wait_lamp(0, 1'b0, 40);
    tx_activity = 1'b1;
    wait_lamp(0, 1'b1, 20);
    hold_lamps(5'h0f, 1);
    tx_activity = 1'b0;
    individual_function_select = 2'h2;
    rx_activity = 1'b1;
    wait_lamp(3, 1'b0, 30);
    rx_activity = 1'b0;
    wait_lamp(3, 1'b1, 40);
    full_duplex = 1'b0;
    repeat (40) @(negedge sys_clk);
    check_lamps(5'h0a);
    collision = 1'b1;
    wait_lamp(2, 1'b1, 30);
    wait_lamp(2, 1'b0, 30);
    collision = 1'b0;
    full_duplex = 1'b1;
    individual_function_select = 2'h3;
    repeat (40) @(negedge sys_clk);
    do_reset(1'b0);
    check_lamps(5'h0e);
    link_speed = 2'h1;
    check_lamps(5'h15);
    link_speed = 2'h0;
    check_lamps(5'h07);
    link_speed = 2'h2;
    rx_activity = 1'b1;
    wait_lamp(1, 1'b0, 30);
    rx_activity = 1'b0;
    link_up = 1'b0;
    // long enough for the enhanced blink units to drain the activity above
    repeat (120) @(negedge sys_clk);
    check_lamps(5'h00);
    link_up = 1'b1;
    isolate_control = 1'b1;
    check_lamps(5'h00);
    isolate_control = 1'b0;
    style_control = 1'b0;
    for (c = 0; c < 16; c++) begin
      led_config = {4{c[3:0]}};
      check_lamps(((16'h8133 >> c) & 16'h0001) != 16'h0000 ? 5'h0f : 5'h00);
    end
    parallel_detect_fault = 1'b1;
    led_config = 16'hcccc;
    check_lamps(5'h0f);
    led_config = 16'h7fe0;
    check_lamps(5'h05);
    led_config = 16'hffff;
    isolate_control = 1'b1;
    check_lamps(5'h0f);
    power_down_control = 1'b1;
    check_lamps(5'h00);
    {isolate_control, power_down_control} = 2'h0;
    led_config = 16'haaaa;
    pulse_stretch_enable = 4'hf;
    activity_tx_only = 1'b1;
    pulse_rx();
    hold_lamps(5'h00, 10);
    tx_activity = 1'b1;
    @(negedge sys_clk);
    tx_activity = 1'b0;
    wait_lamp(0, 1'b1, 10);
    hold_lamps(5'h0f, 2);
    wait_lamp(0, 1'b0, 60);
    combine_disable = 4'h1;
    repeat (8) @(negedge sys_clk);
    tx_activity = 1'b1;
    @(negedge sys_clk);
    tx_activity = 1'b0;
    wait_lamp(1, 1'b1, 10);
    check_lamps(5'h0e);
    print_verdict();
  end
endmodule
